/* core/bpm_ctrl.sv */
// Purpose: operating mode sequencer for mission, brownout, display-only and sleep
// Assumes: I/O RAM byte port, power-good and wake pins pass a three-stage synchroniser
// Notes: mode status byte reads mode in bits 1:0
`timescale 1ns/10ps
`default_nettype none
`include "bpm_cfg.svh"
module bpm_ctrl
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [15:0] IORAM_ADDR,
  input wire logic IORAM_WR,
  input wire logic [7:0] IORAM_WDATA,
  output logic [7:0] IORAM_RDATA,
  input wire logic SYSTEM_POWER_GOOD,
  input wire logic WAKE_TIMER,
  input wire logic PUSHBUTTON,
  input wire logic SEG_WAKE,
  input wire logic SERIAL_RX,
  input wire logic [1:0] BLINK_EN,
  input wire logic SEG_DATA_A,
  input wire logic SEG_DATA_B,
  output logic BLINK_SEGMENT_PIN_A,
  output logic BLINK_SEGMENT_PIN_B,
  output logic PLL_ENABLE,
  output logic PLL_FAST_SEL,
  output logic [2:0] CPU_CLOCK_DIVIDER,
  output logic CPU_RUN,
  output logic CPU_RESTART,
  output logic DIGITAL_PERIPH_ON,
  output logic METERING_ON,
  output logic ALWAYS_ON
);
  typedef struct packed {
    bpm_pkg::bpm_mode_t mode;
    logic [7:0] clkgen;
    logic [1:0] cmd;
    logic [1:0] vmode;
    logic [2:0] s_pg;
    logic [2:0] s_wk;
    logic pg;
    logic wk;
    logic [3:0] brief;
    logic [23:0] blink;
    logic restart;
    logic [7:0] rdata;
  } bpm_state_t;
  bpm_state_t st;
  bpm_state_t next_st;
  logic wake_raw;
  assign wake_raw = WAKE_TIMER | PUSHBUTTON | SEG_WAKE | SERIAL_RX;
  always_comb
  begin
    next_st = st;
    next_st.s_pg = {st.s_pg[1:0], SYSTEM_POWER_GOOD};
    next_st.s_wk = {st.s_wk[1:0], wake_raw};
    if (st.s_pg[2] == st.s_pg[1])
    begin
      next_st.pg = st.s_pg[2];
    end
    if (st.s_wk[2] == st.s_wk[1])
    begin
      next_st.wk = st.s_wk[2];
    end
    next_st.restart = 1'b0;
    next_st.blink = st.blink + 24'h1;
    if (st.blink == `BPM_BLINK_MAX)
    begin
      next_st.blink = '0;
    end
    if (IORAM_WR)
    begin
      case (IORAM_ADDR)
        `BPM_ADDR_CLKGEN: next_st.clkgen = IORAM_WDATA; // [R03]
        `BPM_ADDR_MODECTL: next_st.cmd = {IORAM_WDATA[`BPM_BIT_SLEEP], IORAM_WDATA[`BPM_BIT_LCDONLY]};
        `BPM_ADDR_LCDCFG: next_st.vmode = IORAM_WDATA[`BPM_VMODE_MSB:`BPM_VMODE_LSB];
        default: next_st.cmd = st.cmd;
      endcase
    end
    case (IORAM_ADDR)
      `BPM_ADDR_CLKGEN: next_st.rdata = st.clkgen;
      `BPM_ADDR_MODECTL: next_st.rdata = {st.cmd, 6'h0};
      `BPM_ADDR_LCDCFG: next_st.rdata = {st.vmode, 6'h0};
      `BPM_ADDR_MODESTAT: next_st.rdata = {6'h0, st.mode}; // [R19]
      default: next_st.rdata = 8'h00;
    endcase
    case (st.mode)
      bpm_pkg::BPM_MSN_MODE:
      begin
        if (!st.pg)
        begin
          next_st.mode = bpm_pkg::BPM_BRN_MODE; // [R17] [R02]
        end
        else if (st.cmd != 2'h0)
        begin
          next_st.mode = st.cmd[1] ? bpm_pkg::BPM_SLP_MODE : bpm_pkg::BPM_LCD_MODE; // [R08]
          next_st.brief = '0;
        end
      end
      bpm_pkg::BPM_BRN_MODE:
      begin
        if (st.pg)
        begin
          next_st.mode = bpm_pkg::BPM_MSN_MODE; // [R05]
        end
        else if (st.cmd[1])
        begin
          next_st.mode = bpm_pkg::BPM_SLP_MODE; // [R04]
        end
        else if (st.cmd[0])
        begin
          next_st.mode = bpm_pkg::BPM_LCD_MODE; // [R04] [R07]
        end
      end
      default:
      begin
        next_st.brief = st.brief + 4'h1;
        if (st.pg && st.brief == `BPM_BRIEF_CYC)
        begin
          next_st.mode = bpm_pkg::BPM_MSN_MODE; // [R08]
        end
        else if (st.wk && !st.pg)
        begin
          next_st.mode = bpm_pkg::BPM_BRN_MODE; // [R18]
        end
        if (next_st.mode != st.mode)
        begin
          next_st.restart = 1'b1; // [R13]
          next_st.cmd = 2'h0;
          next_st.clkgen = `BPM_CLKGEN_RST; // [R13] vmode kept as nv [R14]
        end
      end
    endcase
  end
  always_ff @(posedge SYS_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st <= '{mode: bpm_pkg::BPM_MSN_MODE, clkgen: `BPM_CLKGEN_RST, s_pg: `BPM_SYNC_RST,
        pg: `BPM_PG_RST, default: '0};
    end
    else
    begin
      st <= next_st;
    end
  end
  logic dispm;
  assign dispm = (st.mode == bpm_pkg::BPM_LCD_MODE);
  assign IORAM_RDATA = st.rdata;
  assign PLL_ENABLE = (st.mode == bpm_pkg::BPM_MSN_MODE) || (st.mode == bpm_pkg::BPM_BRN_MODE)
    || (dispm && st.vmode == `BPM_VMODE_BOOST); // [R10]
  assign PLL_FAST_SEL = st.clkgen[`BPM_BIT_FAST]; // [R03]
  assign CPU_CLOCK_DIVIDER = st.clkgen[`BPM_DIV_MSB:0]; // [R03]
  assign CPU_RUN = (st.mode == bpm_pkg::BPM_MSN_MODE) || (st.mode == bpm_pkg::BPM_BRN_MODE); // [R11] [R17]
  assign CPU_RESTART = st.restart;
  assign DIGITAL_PERIPH_ON = CPU_RUN; // [R01]
  assign METERING_ON = (st.mode == bpm_pkg::BPM_MSN_MODE); // [R15]
  assign ALWAYS_ON = 1'b1; // [R16]
  assign BLINK_SEGMENT_PIN_A = SEG_DATA_A & ~(dispm & BLINK_EN[0] & st.blink[`BPM_BLINK_BIT]); // [R12] [R11]
  assign BLINK_SEGMENT_PIN_B = SEG_DATA_B & ~(dispm & BLINK_EN[1] & st.blink[`BPM_BLINK_BIT]); // [R12]
  sequence seq_msn_to_brn;
    st.mode == bpm_pkg::BPM_MSN_MODE ##1 st.mode == bpm_pkg::BPM_BRN_MODE;
  endsequence
  sequence seq_disp_exit;
    dispm ##1 !dispm;
  endsequence
  AST_PG_LOSS: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R17]
    (st.mode == bpm_pkg::BPM_MSN_MODE && !st.pg) |=> st.mode == bpm_pkg::BPM_BRN_MODE)
    else $error("no brownout after power loss");
  AST_PG_SYNC: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R17]
    $changed(st.pg) |-> $past(st.s_pg[2]) == st.pg && $past(st.s_pg[1]) == st.pg)
    else $error("power good taken before stages agree");
  AST_PG_BACK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R05]
    (st.mode == bpm_pkg::BPM_BRN_MODE && st.pg) |=> METERING_ON)
    else $error("no mission after power return");
  AST_METER: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R15]
    !st.pg |=> !METERING_ON)
    else $error("metering without system power");
  AST_PLL_DISP: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R10]
    dispm |-> PLL_ENABLE == (st.vmode == `BPM_VMODE_BOOST))
    else $error("pll wrong in display mode");
  AST_PLL_OFF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R10]
    (st.mode == bpm_pkg::BPM_SLP_MODE || (dispm && st.vmode != `BPM_VMODE_BOOST))
    |-> !PLL_ENABLE)
    else $error("pll left running in low power mode");
  AST_BRN_CLK: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R02]
    seq_msn_to_brn |-> $stable(PLL_FAST_SEL) && $stable(CPU_CLOCK_DIVIDER))
    else $error("pll speed changed at brownout");
  AST_BRN_PERIPH: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R01]
    st.mode == bpm_pkg::BPM_BRN_MODE |-> DIGITAL_PERIPH_ON && CPU_RUN)
    else $error("peripherals off in brownout");
  AST_LCD_CMD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R07]
    (st.mode == bpm_pkg::BPM_BRN_MODE && !st.pg && st.cmd == 2'h1) |=> dispm)
    else $error("display command ignored");
  AST_SLP_CMD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R04]
    (st.mode == bpm_pkg::BPM_BRN_MODE && !st.pg && st.cmd[1])
    |=> st.mode == bpm_pkg::BPM_SLP_MODE)
    else $error("sleep command ignored");
  AST_WAKE_BRN: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R18]
    (!CPU_RUN && st.wk && !st.pg) |=> st.mode == bpm_pkg::BPM_BRN_MODE)
    else $error("no brownout after wake event");
  AST_RESTART: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R13]
    seq_disp_exit |-> CPU_RESTART)
    else $error("no restart after display mode");
  AST_RESTART_ONE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R13]
    CPU_RESTART |=> !CPU_RESTART)
    else $error("restart pulse too long");
  AST_EXIT_CFG: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R13]
    seq_disp_exit |-> st.clkgen == `BPM_CLKGEN_RST && st.cmd == 2'h0)
    else $error("configuration kept after display mode");
  AST_VMODE_KEEP: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R14]
    seq_disp_exit |-> $stable(st.vmode))
    else $error("display voltage mode lost");
  AST_BRIEF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R08]
    (st.mode == bpm_pkg::BPM_MSN_MODE && st.pg && st.cmd == 2'h1) |=> ##[1:17] METERING_ON)
    else $error("no wake from brief display mode");
  AST_SLP_BRIEF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R08]
    (st.mode == bpm_pkg::BPM_MSN_MODE && st.pg && st.cmd == 2'h2) |=> ##[1:17] METERING_ON)
    else $error("no wake from brief sleep mode");
  AST_CPU_OFF: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R11]
    dispm |-> !CPU_RUN && !DIGITAL_PERIPH_ON)
    else $error("cpu running in display mode");
  AST_DISP_SEG: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R11]
    (dispm && !st.blink[`BPM_BLINK_BIT]) |-> BLINK_SEGMENT_PIN_A == SEG_DATA_A
    && BLINK_SEGMENT_PIN_B == SEG_DATA_B)
    else $error("segment data not shown in display mode");
  AST_STATUS: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) // [R19]
    IORAM_ADDR == `BPM_ADDR_MODESTAT |=> IORAM_RDATA == {6'h0, $past(st.mode)})
    else $error("mode status wrong");
endmodule
`default_nettype wire

/* core/bpm_cfg.svh */
// Purpose: constants for the battery power mode controller
// Assumes: one 100 MHz clock, I/O RAM reached through a byte-wide port
// Notes: offsets are I/O RAM addresses
// Functional notes
// [R01] brownout keeps emulation port, serial, memory bus, display and clock running.
// [R02] entering brownout leaves pll speed exactly as in mission mode.
// [R03] firmware lowers power via fast-pll bit 4 or divider bits 2:0.
// [R04] from brownout firmware may command display-only or sleep mode.
// [R05] power-good returning in brownout goes to mission mode automatically.
// [R06] firmware should slow pll, max divider, disable analog, halt cpu.
// [R07] setting display-only command bit 6 enters display-only mode.
// [R08] display-only command from mission mode is brief, then wakes immediately.
// [R09] firmware should clear fast-pll select before commanding display-only.
// [R10] display-only keeps pll on only when voltage mode equals binary 10.
// [R11] display-only keeps driving segment data; cpu stays disabled.
// [R12] display-only blinks up to two segment pins without cpu.
// [R13] leaving display-only restarts cpu at zero and resets config bits.
// [R14] non-volatile bits survive display-only mode and return.
// [R15] compute engine, filter and converter run only in mission mode.
// [R16] nv ram, temp sensor, wake timer, oscillator and rtc always on.
// [R17] power-good clearing forces brownout; cpu keeps running across it.
// [R18] wake timer, button, segment edge or serial activity returns to brownout.
// [R19] current mode is readable by firmware.
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH
`define BPM_ADDR_CLKGEN 16'h2200
`define BPM_ADDR_MODECTL 16'h28B2
`define BPM_ADDR_LCDCFG 16'h2401
`define BPM_ADDR_MODESTAT 16'h28B3
`define BPM_BIT_FAST 4
`define BPM_BIT_LCDONLY 6
`define BPM_BIT_SLEEP 7
`define BPM_CLKGEN_RST 8'h14
`define BPM_VMODE_BOOST 2'h2
`define BPM_BLINK_MAX 24'hFFFFFF
`define BPM_BRIEF_CYC 4'hF
`define BPM_VMODE_MSB 7
`define BPM_VMODE_LSB 6
`define BPM_DIV_MSB 2
`define BPM_BLINK_BIT 23
`define BPM_SYNC_RST 3'h7
`define BPM_PG_RST 1'b1
`endif

/* core/bpm_pkg.sv */
package bpm_pkg;
  typedef enum logic [1:0] {BPM_MSN_MODE, BPM_BRN_MODE, BPM_LCD_MODE, BPM_SLP_MODE} bpm_mode_t;
endpackage

/* tb/bpm_ctrl_tb_top.sv */
// Purpose: self-checking bench for the battery power mode controller
// Assumes: byte-wide I/O RAM port, inputs change on the falling clock edge
// Notes: blink period far exceeds the run, so segment pins follow their data
`timescale 1ns/10ps
`default_nettype none
module bpm_ctrl_tb_top;
  logic clk = 0;
  logic rst = 1;
  logic [15:0] addr = 16'h0;
  logic wr = 0;
  logic [7:0] wd = 8'h0;
  logic [7:0] rdat;
  logic pg = 1;
  logic [3:0] wk = 4'h0;
  logic [2:0] div;
  logic bpa, bpb, pll, fast, run, rsx, dig, met, aon;
  int failures = 0;
  int n_compared = 0;
  bpm_ctrl bpm_ctrl_inst (.SYS_CLK(clk), .SYS_RST(rst), .IORAM_ADDR(addr), .IORAM_WR(wr),
    .IORAM_WDATA(wd), .IORAM_RDATA(rdat), .SYSTEM_POWER_GOOD(pg), .WAKE_TIMER(wk[0]),
    .PUSHBUTTON(wk[1]), .SEG_WAKE(wk[2]), .SERIAL_RX(wk[3]), .BLINK_EN(2'h3),
    .SEG_DATA_A(1'b1), .SEG_DATA_B(1'b0), .BLINK_SEGMENT_PIN_A(bpa),
    .BLINK_SEGMENT_PIN_B(bpb), .PLL_ENABLE(pll), .PLL_FAST_SEL(fast),
    .CPU_CLOCK_DIVIDER(div), .CPU_RUN(run), .CPU_RESTART(rsx), .DIGITAL_PERIPH_ON(dig),
    .METERING_ON(met), .ALWAYS_ON(aon));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
  begin
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr8(input logic [15:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  end
  endtask
  task automatic rd8(input logic [15:0] a, input logic [7:0] e, input string what);
  begin
    @(negedge clk);
    addr = a;
    @(negedge clk);
    cmp(rdat, e, what);
  end
  endtask
  task automatic wake(input int src);
    int k;
  begin
    k = 0;
    wk[src] = 1;
    while (rsx !== 1'b1 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    cmp(8'(k < 40), 8'h01, "restart pulse");
    wk[src] = 0;
    cyc(2);
    rd8(16'h28B3, 8'h01, "woke to brownout");
  end
  endtask
  task automatic results;
  begin
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  initial
  begin
    cyc(8);
    rst = 0;
    cyc(5);
    rd8(16'h2200, 8'h14, "clkgen reset");
    rd8(16'h28B3, 8'h00, "mission");
    cmp({4'h0, met, aon, run, pll}, 8'h0F, "mission outputs");
    rd8(16'h3000, 8'h00, "unmapped read");
    $display("test reset done");
    pg = 0;
    cyc(6);
    rd8(16'h28B3, 8'h01, "brownout");
    cmp({met, dig, run, pll, fast, div}, 8'h7C, "brownout outputs");
    wr8(16'h2200, 8'h24);
    rd8(16'h2200, 8'h24, "clkgen write");
    cmp({4'h0, fast, div}, 8'h04, "slow pll max div");
    $display("test brownout done");
    wr8(16'h2401, 8'h80);
    wr8(16'h28B2, 8'h40);
    cyc(2);
    rd8(16'h28B3, 8'h02, "display mode");
    cmp({4'h0, run, pll, bpa, bpb}, 8'h06, "display outputs");
    wake(0);
    rd8(16'h2200, 8'h14, "clkgen after wake");
    rd8(16'h2401, 8'h80, "vmode kept");
    $display("test display done");
    wr8(16'h2401, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      wr8(16'h28B2, i[0] ? 8'h80 : 8'h40);
      cyc(2);
      rd8(16'h28B3, i[0] ? 8'h03 : 8'h02, "low power mode");
      cmp({7'h0, pll}, 8'h00, "pll off");
      wake(i);
    end
    $display("test wake sources done");
    pg = 1;
    cyc(6);
    rd8(16'h28B3, 8'h00, "power back");
    cmp({7'h0, met}, 8'h01, "metering on");
    wr8(16'h28B2, 8'h40);
    rd8(16'h28B3, 8'h02, "brief display entered");
    cyc(40);
    rd8(16'h28B3, 8'h00, "brief display");
    wr8(16'h28B2, 8'h80);
    rd8(16'h28B3, 8'h03, "brief sleep entered");
    cyc(40);
    rd8(16'h28B3, 8'h00, "brief sleep");
    cmp({7'h0, met}, 8'h01, "metering after brief sleep");
    $display("test recovery done");
    results;
  end
  initial
  begin
    #100000;
    failures++;
    $display("[ERR] %0t watchdog expired", $time);
    results;
  end
endmodule
`default_nettype wire
